// file: rtl/avs_pkg.sv
// Constants shared by the audio/video synchronization unit
package avs_pkg;
  // ---------------------------------------------------------------
  // Clock reference counter
  // ---------------------------------------------------------------
  localparam int              SCR_W      = 33;
  localparam int              PRESC_W    = 9;
  localparam int              PRESC_DIV  = 444;
  localparam logic [PRESC_W-1:0] PRESC_LAST = PRESC_W'(PRESC_DIV - 1);
  localparam logic [PRESC_W-1:0] PRESC_ZERO = 9'h000;
  localparam logic [SCR_W-1:0]   SCR_ZERO   = 33'h0_0000_0000;
  localparam logic [SCR_W-1:0]   SCR_ONE    = 33'h0_0000_0001;

  // ---------------------------------------------------------------
  // Time stamp comparison
  // ---------------------------------------------------------------
  localparam logic [SCR_W-1:0] MATCH_TOL   = 33'h0_0000_0BB8;
  localparam logic [SCR_W-1:0] DECODE_BIAS = 33'h0_0000_0BBB;
  localparam int               TS_VLD_BIT  = 15;
  localparam int               TS_WORD_W   = 16;
  localparam int               PERIOD_W    = 16;

  // ---------------------------------------------------------------
  // Picture coding types
  // ---------------------------------------------------------------
  localparam logic [1:0] PIC_I = 2'h1;
  localparam logic [1:0] PIC_P = 2'h2;
  localparam logic [1:0] PIC_B = 2'h3;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 50;
  localparam int FRAME_TIME_NS = 33_367_000;
  localparam int FRAME_CYC     = FRAME_TIME_NS / CLK_PERIOD_NS;
  localparam int FRAME_W       = 20;
  localparam logic [FRAME_W-1:0] FRAME_ZERO = 20'h0_0000;

  typedef enum logic [2:0] {
    AVS_WAIT = 3'b001,
    AVS_CMP  = 3'b010,
    AVS_HOLD = 3'b100
  } avs_state_t;
endpackage

// file: rtl/avs_scr_counter.sv
// Prescaled 33-bit clock reference counter
`timescale 1ns/1ps
module avs_scr_counter (
  // Clock and reset
  input  wire logic                     core_clk,
  input  wire logic                     reset,
  input  wire logic                     clk_en,
  // Control
  input  wire logic                     load,
  input  wire logic [avs_pkg::SCR_W-1:0] load_val,
  input  wire logic                     clear,
  // State
  output logic      [avs_pkg::SCR_W-1:0] scr_value,
  output logic                          scr_tick
);
  import avs_pkg::*;

  logic [PRESC_W-1:0] presc;
  logic [PRESC_W-1:0] next_presc;
  logic [SCR_W-1:0]   next_scr;

  // ---------------------------------------------------------------
  // Divider and counter
  // ---------------------------------------------------------------
  always_comb begin
    scr_tick   = (presc == PRESC_LAST);
    next_presc = scr_tick ? PRESC_ZERO : presc + 9'h001;
    next_scr   = scr_value;
    if (clear) begin
      next_scr = SCR_ZERO;
    end else if (load) begin
      next_scr = load_val;
    end else if (scr_tick) begin
      next_scr = scr_value + SCR_ONE;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      presc     <= PRESC_ZERO;
      scr_value <= SCR_ZERO;
    end else if (clk_en) begin
      presc     <= next_presc;
      scr_value <= next_scr;
    end
  end

  presc_range_a: assert property (@(posedge core_clk) disable iff (reset) presc <= PRESC_LAST)
    else $error("prescaler left its range");
endmodule

// file: rtl/avs_sync_unit.sv
// Audio/video synchronization unit with clock reference and stamp compare
`timescale 1ns/1ps
// Summary of operation
// - Hold a 33-bit clock reference counter
// - Advance counter once every 444 clocks
// - Apply counter write while command flag raised
// - Access command can read counter value
// - Bind packet stamp to first picture start
// - Stamp valid only when word two bit15
// - No stamp since idle/flush/error: no sync
// - Otherwise derive stamp from previous plus rate
// - Within 3000 counts: decode and display
// - Stamp ahead: repeat, wait frame, recompare
// - Stamp behind and B picture: skip it
// - Stamp behind, I or P: decode anyway
// - Still picture done clears counter to zero
module avs_sync_unit #(
  parameter int unsigned FRAME_CYCLES = avs_pkg::FRAME_CYC
) (
  // Clock and reset
  input  wire logic                          core_clk,
  input  wire logic                          reset,
  input  wire logic                          clk_en,
  // Clock reference access command
  input  wire logic                          new_cmd,
  input  wire logic                          cmd_is_write,
  input  wire logic [avs_pkg::SCR_W-1:0]     cmd_wdata,
  output logic                               cmd_clear,
  output logic      [avs_pkg::SCR_W-1:0]     cmd_rdata,
  // Packet descriptor command
  input  wire logic                          pkt_valid,
  input  wire logic [avs_pkg::TS_WORD_W-1:0] first_timestamp_word,
  input  wire logic [avs_pkg::TS_WORD_W-1:0] second_timestamp_word,
  input  wire logic [avs_pkg::TS_WORD_W-1:0] third_timestamp_word,
  // Bitstream events
  input  wire logic                          pic_start,
  input  wire logic                          pic_first_in_pkt,
  input  wire logic [1:0]                    pic_type,
  input  wire logic [avs_pkg::PERIOD_W-1:0]  picture_period,
  input  wire logic                          idle_entry,
  input  wire logic                          bitstream_flush,
  input  wire logic                          data_error,
  input  wire logic                          still_done,
  // Picture decisions
  output logic                               busy,
  output logic                               act_decode,
  output logic                               act_repeat,
  output logic                               act_skip,
  output logic                               act_unsynced,
  // Counter state
  output logic      [avs_pkg::SCR_W-1:0]     scr_value
);
  import avs_pkg::*;

  localparam logic [FRAME_W-1:0] HOLD_LAST = FRAME_W'(FRAME_CYCLES - 1);

  logic               served;
  logic               next_served;
  logic [SCR_W-1:0]   next_rdata;
  logic               cmd_go;
  logic               scr_tick;
  logic               pend_valid;
  logic               next_pend_valid;
  logic [SCR_W-1:0]   pend_pts;
  logic [SCR_W-1:0]   next_pend_pts;
  logic               have_pts;
  logic               next_have_pts;
  logic [SCR_W-1:0]   cur_pts;
  logic [SCR_W-1:0]   next_cur_pts;
  logic [FRAME_W-1:0] hold_cnt;
  logic [FRAME_W-1:0] next_hold_cnt;
  logic [SCR_W-1:0]   pkt_pts;
  logic [SCR_W-1:0]   biased;
  logic [SCR_W-1:0]   diff;
  logic               early;
  logic               late;
  logic               take_pkt;
  logic               next_decode;
  logic               next_repeat;
  logic               next_skip;
  logic               next_unsynced;
  avs_state_t         state;
  avs_state_t         next_state;

  function automatic logic is_b(input logic [1:0] t);
    return t == PIC_B;
  endfunction

  // ---------------------------------------------------------------
  // Counter
  // ---------------------------------------------------------------
  avs_scr_counter u_scr (
    .core_clk  (core_clk),
    .reset     (reset),
    .clk_en    (clk_en),
    .load      (cmd_go && cmd_is_write),
    .load_val  (cmd_wdata),
    .clear     (still_done),
    .scr_value (scr_value),
    .scr_tick  (scr_tick)
  );

  // ---------------------------------------------------------------
  // Access command
  // ---------------------------------------------------------------
  always_comb begin
    // A frozen clock cannot apply the write, so the flag must not be cleared then
    cmd_go      = new_cmd && !served && clk_en;
    cmd_clear   = cmd_go;
    next_served = new_cmd;
    next_rdata  = cmd_go && !cmd_is_write ? scr_value : cmd_rdata;
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      served    <= 1'b0;
      cmd_rdata <= SCR_ZERO;
    end else if (clk_en) begin
      served    <= next_served;
      cmd_rdata <= next_rdata;
    end
  end

  // ---------------------------------------------------------------
  // Stamps and picture sequencing
  // ---------------------------------------------------------------
  always_comb begin
    pkt_pts  = {first_timestamp_word[2:0], second_timestamp_word[14:0], third_timestamp_word[14:0]};
    take_pkt = pkt_valid && second_timestamp_word[TS_VLD_BIT];
    biased   = scr_value + DECODE_BIAS;
    diff     = cur_pts - biased;
    early    = !diff[SCR_W-1] && (diff > MATCH_TOL);
    late     = diff[SCR_W-1] && ((SCR_ZERO - diff) > MATCH_TOL);

    next_state      = state;
    next_pend_valid = pend_valid;
    next_pend_pts   = pend_pts;
    next_have_pts   = have_pts;
    next_cur_pts    = cur_pts;
    next_hold_cnt   = hold_cnt;
    next_decode     = 1'b0;
    next_repeat     = 1'b0;
    next_skip       = 1'b0;
    next_unsynced   = 1'b0;

    if (idle_entry || bitstream_flush || data_error) begin
      next_have_pts   = 1'b0;
      next_pend_valid = 1'b0;
    end

    unique case (state)
      AVS_WAIT: begin
        if (pic_start) begin
          next_state = AVS_CMP;
          if (pic_first_in_pkt && pend_valid) begin
            next_cur_pts    = pend_pts;
            next_pend_valid = 1'b0;
            next_have_pts   = 1'b1;
          end else begin
            next_cur_pts = cur_pts + SCR_W'(picture_period);
          end
        end
      end
      AVS_CMP: begin
        if (!have_pts) begin
          next_decode   = 1'b1;
          next_unsynced = 1'b1;
          next_state    = AVS_WAIT;
        end else if (early) begin
          next_repeat   = 1'b1;
          next_hold_cnt = FRAME_ZERO;
          next_state    = AVS_HOLD;
        end else if (late && is_b(pic_type)) begin
          next_skip  = 1'b1;
          next_state = AVS_WAIT;
        end else begin
          next_decode = 1'b1;
          next_state  = AVS_WAIT;
        end
      end
      AVS_HOLD: begin
        next_hold_cnt = hold_cnt + 20'h0_0001;
        if (hold_cnt == HOLD_LAST) begin
          next_state = AVS_CMP;
        end
      end
    endcase

    if (take_pkt) begin
      next_pend_valid = 1'b1;
      next_pend_pts   = pkt_pts;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      state        <= AVS_WAIT;
      pend_valid   <= 1'b0;
      pend_pts     <= SCR_ZERO;
      have_pts     <= 1'b0;
      cur_pts      <= SCR_ZERO;
      hold_cnt     <= FRAME_ZERO;
      act_decode   <= 1'b0;
      act_repeat   <= 1'b0;
      act_skip     <= 1'b0;
      act_unsynced <= 1'b0;
    end else if (clk_en) begin
      state        <= next_state;
      pend_valid   <= next_pend_valid;
      pend_pts     <= next_pend_pts;
      have_pts     <= next_have_pts;
      cur_pts      <= next_cur_pts;
      hold_cnt     <= next_hold_cnt;
      act_decode   <= next_decode;
      act_repeat   <= next_repeat;
      act_skip     <= next_skip;
      act_unsynced <= next_unsynced;
    end
  end

  assign busy = (state != AVS_WAIT);

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  cmd_write_a: assert property (@(posedge core_clk) disable iff (reset)
    (clk_en && cmd_clear && cmd_is_write && !still_done) |=> scr_value == $past(cmd_wdata))
    else $error("counter write not applied");
  cmd_read_a: assert property (@(posedge core_clk) disable iff (reset)
    (clk_en && cmd_clear && !cmd_is_write) |=> cmd_rdata == $past(scr_value))
    else $error("counter read wrong");
  clear_flag_a: assert property (@(posedge core_clk) disable iff (reset)
    cmd_clear |-> (new_cmd && clk_en) ##1 !cmd_clear)
    else $error("flag cleared without command or twice");
  scr_step_a: assert property (@(posedge core_clk) disable iff (reset)
    (clk_en && scr_tick && !cmd_go && !still_done) |=> scr_value == $past(scr_value) + SCR_ONE)
    else $error("counter did not advance");
  still_zero_a: assert property (@(posedge core_clk) disable iff (reset)
    (clk_en && still_done) |=> scr_value == SCR_ZERO)
    else $error("counter not cleared after still");
  stamp_take_a: assert property (@(posedge core_clk) disable iff (reset)
    (clk_en && pkt_valid && second_timestamp_word[TS_VLD_BIT]) |=> pend_valid && pend_pts == $past(pkt_pts))
    else $error("valid stamp not captured");
  stamp_ignore_a: assert property (@(posedge core_clk) disable iff (reset)
    (clk_en && pkt_valid && !second_timestamp_word[TS_VLD_BIT] && !pend_valid) |=> !pend_valid)
    else $error("invalid stamp captured");
  synth_pts_a: assert property (@(posedge core_clk) disable iff (reset)
    (clk_en && state == AVS_WAIT && pic_start && !(pic_first_in_pkt && pend_valid))
      |=> cur_pts == $past(cur_pts) + SCR_W'($past(picture_period)))
    else $error("derived stamp wrong");
  no_sync_a: assert property (@(posedge core_clk) disable iff (reset)
    (clk_en && state == AVS_CMP && !have_pts) |=> act_decode && act_unsynced)
    else $error("unsynced picture not decoded");
  early_rep_a: assert property (@(posedge core_clk) disable iff (reset)
    (clk_en && state == AVS_CMP && have_pts && early) |=> act_repeat && state == AVS_HOLD)
    else $error("early picture not repeated");
  late_skip_a: assert property (@(posedge core_clk) disable iff (reset)
    (clk_en && state == AVS_CMP && have_pts && late && is_b(pic_type)) |=> act_skip && !act_decode)
    else $error("late B picture not skipped");
  late_keep_a: assert property (@(posedge core_clk) disable iff (reset)
    (clk_en && state == AVS_CMP && have_pts && late && !is_b(pic_type)) |=> act_decode)
    else $error("late reference picture skipped");
  match_dec_a: assert property (@(posedge core_clk) disable iff (reset)
    (clk_en && state == AVS_CMP && have_pts && !early && !late) |=> act_decode && !act_repeat)
    else $error("matching picture not decoded");

  decode_c: cover property (@(posedge core_clk) disable iff (reset) act_decode && !act_unsynced);
  repeat_c: cover property (@(posedge core_clk) disable iff (reset) act_repeat);
  skip_c:   cover property (@(posedge core_clk) disable iff (reset) act_skip);
  write_c:  cover property (@(posedge core_clk) disable iff (reset) cmd_clear && cmd_is_write);
endmodule

// file: testbench/avs_host_model.sv
// Host model issuing access and packet descriptor commands
`timescale 1ns/1ps
module avs_host_model (
  // Clock and access command
  input  wire logic                          core_clk,
  input  wire logic                          cmd_clear,
  input  wire logic [avs_pkg::SCR_W-1:0]     cmd_rdata,
  output logic                               new_cmd,
  output logic                               cmd_is_write,
  output logic      [avs_pkg::SCR_W-1:0]     cmd_wdata,
  // Packet descriptor command
  output logic                               pkt_valid,
  output logic      [avs_pkg::TS_WORD_W-1:0] ts1,
  output logic      [avs_pkg::TS_WORD_W-1:0] ts2,
  output logic      [avs_pkg::TS_WORD_W-1:0] ts3
);
  import avs_pkg::*;
  // --------------------------------
  // Host commands
  // --------------------------------
  initial begin
    {new_cmd, cmd_is_write, pkt_valid} = 3'h0;
    {cmd_wdata, ts1, ts2, ts3} = '0;
  end
  // Flag stays up until the device clears it or 20 cycles pass, then drops for a cycle
  task automatic access(input logic wr, input logic [SCR_W-1:0] d, output logic [SCR_W-1:0] q, output logic ok);
    ok = 1'b0;
    @(posedge core_clk);
    new_cmd <= 1'b1;
    cmd_is_write <= wr;
    cmd_wdata <= d;
    for (int i = 0; i < 20 && !ok; i++) begin
      @(negedge core_clk);
      ok = (cmd_clear === 1'b1);
    end
    @(posedge core_clk);
    new_cmd <= 1'b0;
    cmd_is_write <= ~wr;
    cmd_wdata <= ~d;
    #1;
    q = cmd_rdata;
  endtask
  // Released stamp words show the inverse of their last value
  task automatic send_pkt(input logic [SCR_W-1:0] s, input logic vld);
    @(posedge core_clk);
    pkt_valid <= 1'b1;
    ts1 <= {13'h0000, s[32:30]};
    ts2 <= {vld, s[29:15]};
    ts3 <= {1'b0, s[14:0]};
    @(posedge core_clk);
    pkt_valid <= 1'b0;
    {ts1, ts2, ts3} <= ~{ts1, ts2, ts3};
  endtask
endmodule

// file: testbench/tb_av_sync_clock_reference.sv
// Self-checking testbench of the audio/video synchronization unit
`timescale 1ns/1ps
module tb_av_sync_clock_reference;
  import avs_pkg::*;
  // --------------------------------
  // Signals, design and host
  // --------------------------------
  logic                 core_clk, reset, clk_en, pic_start, pic_first_in_pkt, still_done, ok;
  logic                 new_cmd, cmd_is_write, cmd_clear, pkt_valid;
  logic                 busy, act_decode, act_repeat, act_skip, act_unsynced;
  logic [1:0]           pic_type;
  logic [2:0]           forget;
  logic [3:0]           act;
  logic [PERIOD_W-1:0]  picture_period;
  logic [TS_WORD_W-1:0] ts1, ts2, ts3;
  logic [SCR_W-1:0]     cmd_wdata, cmd_rdata, scr_value, q, stamp;
  int                   n_mismatch, samples_checked, n;

  avs_sync_unit #(.FRAME_CYCLES(8)) uut (
    .core_clk(core_clk), .reset(reset), .clk_en(clk_en),
    .new_cmd(new_cmd), .cmd_is_write(cmd_is_write), .cmd_wdata(cmd_wdata),
    .cmd_clear(cmd_clear), .cmd_rdata(cmd_rdata), .pkt_valid(pkt_valid),
    .first_timestamp_word(ts1), .second_timestamp_word(ts2), .third_timestamp_word(ts3),
    .pic_start(pic_start), .pic_first_in_pkt(pic_first_in_pkt), .pic_type(pic_type),
    .picture_period(picture_period), .idle_entry(forget[0]), .bitstream_flush(forget[1]),
    .data_error(forget[2]), .still_done(still_done), .busy(busy), .act_decode(act_decode),
    .act_repeat(act_repeat), .act_skip(act_skip), .act_unsynced(act_unsynced), .scr_value(scr_value)
  );
  avs_host_model host (
    .core_clk(core_clk), .cmd_clear(cmd_clear), .cmd_rdata(cmd_rdata), .new_cmd(new_cmd),
    .cmd_is_write(cmd_is_write), .cmd_wdata(cmd_wdata), .pkt_valid(pkt_valid),
    .ts1(ts1), .ts2(ts2), .ts3(ts3)
  );
  always #25 core_clk = ~core_clk;

  task automatic results();
    $display("comparisons %0d, mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic chk(input logic [SCR_W-1:0] got, input logic [SCR_W-1:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic timed_out();
    n_mismatch++;
    $display("no answer by %0t", $time);
    results();
  endtask
  task automatic acc(input logic wr, input logic [SCR_W-1:0] d);
    host.access(wr, d, q, ok);
    if (!ok) timed_out();
  endtask
  // Counts cycles until the counter moves
  task automatic wait_chg();
    logic [SCR_W-1:0] old;
    old = scr_value;
    n = 0;
    do begin
      @(posedge core_clk);
      #1;
      n++;
    end while (scr_value === old && n < 500);
    if (n >= 500) timed_out();
  endtask
  task automatic wait_act();
    act = 4'h0;
    for (int i = 0; i < 40 && act === 4'h0; i++) begin
      @(posedge core_clk);
      #1;
      act = {act_unsynced, act_skip, act_repeat, act_decode};
    end
    if (act === 4'h0) timed_out();
  endtask
  task automatic pic(input logic [1:0] t, input logic first, input logic [PERIOD_W-1:0] per);
    @(posedge core_clk);
    pic_start <= 1'b1;
    pic_type <= t;
    pic_first_in_pkt <= first;
    picture_period <= per;
    @(posedge core_clk);
    pic_start <= 1'b0;
    #1;
    chk(SCR_W'(busy), SCR_ONE);
    wait_act();
    chk(SCR_W'(busy), SCR_W'(act[1]));
  endtask

  task automatic t_counter();
    acc(1'b1, 33'h1_2345_6789);
    chk(scr_value, 33'h1_2345_6789);
    acc(1'b0, 33'h0_0000_0000);
    chk(SCR_W'((q - 33'h1_2345_6789) <= SCR_ONE), SCR_ONE);
    wait_chg();
    wait_chg();
    chk(SCR_W'(n), 33'h0_0000_01BC);
    acc(1'b1, 33'h1_FFFF_FFFF);
    wait_chg();
    chk(scr_value, SCR_ZERO);
  endtask
  // Counter sits near zero, so late stamps wrap below it
  task automatic t_sync();
    logic [SCR_W-1:0] offs[4] = '{33'h0_0000_07D0, 33'h1_FFFF_F060, 33'h1_FFFF_F060, 33'h1_FFFF_F060};
    logic [1:0]       typ[4] = '{PIC_I, PIC_B, PIC_I, PIC_P};
    logic [3:0]       exp[4] = '{4'h1, 4'h4, 4'h1, 4'h1};
    for (int i = 0; i < 4; i++) begin
      stamp = scr_value + DECODE_BIAS + offs[i];
      host.send_pkt(stamp, 1'b1);
      pic(typ[i], 1'b1, 16'h0BB9);
      chk(SCR_W'(act), SCR_W'(exp[i]));
    end
  endtask
  task automatic t_derive();
    stamp = scr_value + DECODE_BIAS;
    host.send_pkt(stamp, 1'b1);
    pic(PIC_I, 1'b1, 16'h1388);
    chk(SCR_W'(act), 33'h0_0000_0001);
    pic(PIC_B, 1'b0, 16'h1388);
    chk(SCR_W'(act), 33'h0_0000_0002);
    acc(1'b1, stamp + 33'h0_0000_1388 - DECODE_BIAS);
    wait_act();
    chk(SCR_W'(act), 33'h0_0000_0001);
  endtask
  task automatic t_forget();
    for (int i = 0; i < 3; i++) begin
      host.send_pkt(scr_value + DECODE_BIAS, 1'b1);
      @(posedge core_clk);
      forget <= 3'(1 << i);
      @(posedge core_clk);
      forget <= 3'h0;
      host.send_pkt(scr_value + DECODE_BIAS, 1'b0);
      pic(PIC_I, 1'b1, 16'h0BB9);
      chk(SCR_W'(act), 33'h0_0000_0009);
    end
  endtask
  task automatic t_still();
    acc(1'b1, 33'h0_ABCD_0000);
    @(posedge core_clk);
    still_done <= 1'b1;
    @(posedge core_clk);
    still_done <= 1'b0;
    #1;
    chk(scr_value, SCR_ZERO);
    acc(1'b1, 33'h0_ABCD_0000);
    chk(scr_value, 33'h0_ABCD_0000);
  endtask
  // Enable low: counter frozen and a command is left unanswered
  task automatic t_freeze();
    @(posedge core_clk);
    clk_en <= 1'b0;
    #1;
    stamp = scr_value;
    host.access(1'b1, 33'h0_0000_0055, q, ok);
    repeat (450) @(posedge core_clk);
    #1;
    chk(SCR_W'(ok), SCR_ZERO);
    chk(scr_value, stamp);
    @(posedge core_clk);
    clk_en <= 1'b1;
    wait_chg();
    chk(scr_value, stamp + SCR_ONE);
  endtask

  initial begin
    core_clk = 1'b0;
    reset = 1'b1;
    clk_en = 1'b1;
    {pic_start, pic_first_in_pkt, still_done} = 3'h0;
    pic_type = PIC_I;
    picture_period = 16'h0000;
    forget = 3'h0;
    n_mismatch = 0;
    samples_checked = 0;
    repeat (12) @(posedge core_clk);
    reset <= 1'b0;
    @(posedge core_clk);
    #1;
    chk(scr_value, SCR_ZERO);
    t_counter();
    t_sync();
    t_derive();
    t_forget();
    t_still();
    t_freeze();
    results();
  end
endmodule
